/* pkg/iabc_pkg.sv */
package iabc_pkg;

  // Register indices and byte addresses
  localparam logic [7:0] OWN_ADDR_IDX = 8'hE0;
  localparam logic [7:0] RATE_IDX = 8'hE1;
  localparam logic [11:0] OWN_ADDR_OFS = {2'b00, OWN_ADDR_IDX, 2'b00};
  localparam logic [11:0] RATE_OFS = {2'b00, RATE_IDX, 2'b00};
  localparam logic [11:0] CTRL_OFS = 12'h388;
  localparam logic [11:0] STATUS_OFS = 12'h38C;
  localparam logic [11:0] TXDATA_OFS = 12'h390;

  // Reset values
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [5:0] RATE_RST = 6'h00;
  localparam logic [7:0] TXDATA_RST = 8'h00;

  // Field positions
  localparam int unsigned CTRL_MS_BIT = 0;
  localparam int unsigned RATE_CODE_W = 6;
  localparam int unsigned STAT_ARB_BIT = 0;
  localparam int unsigned STAT_MATCH_BIT = 1;

  // Tap tables indexed by tap_select and prescale_select
  localparam logic [7:0] SCL_TAP [8] = '{8'h05, 8'h06, 8'h07, 8'h08,
                                         8'h09, 8'h0A, 8'h0C, 8'h0F};
  localparam logic [7:0] SDA_TAP [8] = '{8'h01, 8'h01, 8'h02, 8'h02,
                                         8'h03, 8'h03, 8'h04, 8'h04};
  localparam logic [7:0] FIRST_TAP_DELAY [8] = '{8'h04, 8'h04, 8'h06, 8'h06,
                                                 8'h0E, 8'h1E, 8'h3E, 8'h7E};

  // Fixed pipeline additions to the half period and hold count
  localparam logic [11:0] HALF_EXTRA = 12'h002;
  localparam logic [11:0] HOLD_EXTRA = 12'h003;
  // Release to high count start, plus the final count cycle
  localparam logic [11:0] HIGH_LAG = 12'h004;
  localparam logic [11:0] HALF_MIN = 12'h00A;
  localparam logic [11:0] HALF_MAX = 12'h780;
  localparam logic [11:0] HOLD_MIN = 12'h007;
  localparam logic [11:0] HOLD_MAX = 12'h201;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  typedef enum logic [2:0] {
    M_IDLE, M_START, M_LOW, M_HIGHWAIT, M_HIGH, M_PAUSE, M_STOPLOW, M_STOPHIGH
  } iabc_mstate_t;

  typedef struct packed {
    logic byteDone;
    logic slaveRw;
    logic busBusy;
    logic addrMatch;
    logic arbLost;
  } iabc_status_t;

endpackage : iabc_pkg

/* verilog/iabc_core.sv */
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module iabc_core
  import iabc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic masterActive
);

  logic sclMeta, sclSync, sclPrev;
  logic sdaMeta, sdaSync, sdaPrev;
  logic [7:0] ownAddr;
  logic [5:0] rateCode;
  logic [7:0] txData;
  logic masterSelect, startReq, txPending;
  iabc_status_t status;
  iabc_mstate_t state, next_state;
  logic [11:0] cnt;
  logic [3:0] bitIdx;
  logic [7:0] txShift;
  logic sdaDrive, sclDrive;
  logic [11:0] halfDiv, holdCnt, tapSpacing;
  logic [2:0] prescaleSelect, tapSelect;
  logic lost, endBit, startSeen, stopSeen, sclRise;
  logic slvActive;
  logic [3:0] slvCnt;
  logic [6:0] slvShift;
  logic apbSetup, apbWrite, addrHit;
  logic [31:0] readData;
  logic wrOwn, wrRate, wrCtrl, wrStatus, wrTx;

  // Line synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
    end else begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclSync;
      sdaPrev <= sdaSync;
    end
  end

  assign startSeen = sclSync && sclPrev && sdaPrev && !sdaSync;
  assign stopSeen = sclSync && sclPrev && !sdaPrev && sdaSync;
  assign sclRise = sclSync && !sclPrev;

  // Bit clock generator
  assign prescaleSelect = rateCode[5:3];
  assign tapSelect = rateCode[2:0];
  assign tapSpacing = 12'h001 << prescaleSelect;
  assign halfDiv = {4'h0, FIRST_TAP_DELAY[prescaleSelect]}
                 + 12'((SCL_TAP[tapSelect] - 8'h01) * tapSpacing) + HALF_EXTRA;
  assign holdCnt = {4'h0, FIRST_TAP_DELAY[prescaleSelect]}
                 + 12'((SDA_TAP[tapSelect] - 8'h01) * tapSpacing) + HOLD_EXTRA;

  // APB decode
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrHit;

  always_comb begin
    readData = 32'h0000_0000;
    addrHit = 1'b1;
    if (paddr == OWN_ADDR_OFS) begin
      readData = {24'h00_0000, ownAddr};
    end else if (paddr == RATE_OFS) begin
      readData = {26'h000_0000, rateCode};
    end else if (paddr == CTRL_OFS) begin
      readData = {31'h0000_0000, masterSelect};
    end else if (paddr == STATUS_OFS) begin
      readData = {27'h000_0000, status};
    end else if (paddr == TXDATA_OFS) begin
      readData = {24'h00_0000, txData};
    end else begin
      addrHit = 1'b0;
    end
  end

  assign wrOwn = apbWrite && paddr == OWN_ADDR_OFS;
  assign wrRate = apbWrite && paddr == RATE_OFS;
  assign wrCtrl = apbWrite && paddr == CTRL_OFS;
  assign wrStatus = apbWrite && paddr == STATUS_OFS;
  assign wrTx = apbWrite && paddr == TXDATA_OFS;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (apbSetup) begin
      prdata <= readData;
    end
  end

  // Software registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ownAddr <= OWN_ADDR_RST;
      rateCode <= RATE_RST;
      txData <= TXDATA_RST;
    end else begin
      if (wrOwn) begin
        ownAddr <= {pwdata[7:1], 1'b0};
      end
      if (wrRate) begin
        rateCode <= pwdata[RATE_CODE_W-1:0];
      end
      if (wrTx) begin
        txData <= pwdata[7:0];
      end
    end
  end

  // Master select, start and stop requests
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      masterSelect <= 1'b0;
    end else if (lost) begin
      masterSelect <= 1'b0;
    end else if (wrCtrl) begin
      masterSelect <= pwdata[CTRL_MS_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      startReq <= 1'b0;
    end else if (wrCtrl && !masterSelect && pwdata[CTRL_MS_BIT]) begin
      startReq <= 1'b1;
    end else if (lost || state == M_START || (wrCtrl && !pwdata[CTRL_MS_BIT])) begin
      startReq <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txPending <= 1'b0;
    end else if (wrTx) begin
      txPending <= 1'b1;
    end else if ((state == M_PAUSE && next_state == M_LOW)
        || (state == M_IDLE && next_state == M_START)) begin
      txPending <= 1'b0;
    end
  end

  // Master bit sequencer
  assign lost = state == M_HIGH && bitIdx <= LAST_DATA_BIT && !sdaDrive && !sdaSync;
  assign endBit = state == M_HIGH && (!sclSync || cnt == halfDiv - HIGH_LAG);

  always_comb begin
    next_state = state;
    case (state)
      M_IDLE: begin
        if (startReq && masterSelect && !status.busBusy) begin
          next_state = M_START;
        end
      end
      M_START: begin
        if (cnt == halfDiv - 12'h001) begin
          next_state = M_LOW;
        end
      end
      M_LOW: begin
        if (cnt == halfDiv - 12'h001) begin
          next_state = M_HIGHWAIT;
        end
      end
      M_HIGHWAIT: begin
        if (sclSync) begin
          next_state = M_HIGH;
        end
      end
      M_HIGH: begin
        if (lost) begin
          next_state = M_IDLE;
        end else if (endBit) begin
          next_state = (bitIdx == ACK_BIT) ? M_PAUSE : M_LOW;
        end
      end
      M_PAUSE: begin
        if (!masterSelect) begin
          next_state = M_STOPLOW;
        end else if (txPending) begin
          next_state = M_LOW;
        end
      end
      M_STOPLOW: begin
        if (cnt == halfDiv - 12'h001) begin
          next_state = M_STOPHIGH;
        end
      end
      M_STOPHIGH: begin
        if (sclSync && cnt == halfDiv - 12'h001) begin
          next_state = M_IDLE;
        end
      end
      default: begin
        next_state = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= M_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Period counter, held at zero while the line is still low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 12'h000;
    end else if (next_state != state) begin
      cnt <= 12'h000;
    end else if (state == M_HIGHWAIT || state == M_IDLE || state == M_PAUSE) begin
      cnt <= 12'h000;
    end else if (state == M_STOPHIGH && !sclSync) begin
      cnt <= 12'h000;
    end else begin
      cnt <= cnt + 12'h001;
    end
  end

  // Bit index and shift register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bitIdx <= 4'h0;
      txShift <= 8'h00;
    end else if (state == M_IDLE && next_state == M_START) begin
      bitIdx <= 4'h0;
      txShift <= txData;
    end else if (state == M_PAUSE && next_state == M_LOW) begin
      bitIdx <= 4'h0;
      txShift <= txData;
    end else if (endBit && !lost) begin
      bitIdx <= bitIdx + 4'h1;
      txShift <= {txShift[6:0], 1'b1};
    end
  end

  // Data line drive, changed one hold count after the clock falls
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdaDrive <= 1'b0;
    end else if (lost) begin
      sdaDrive <= 1'b0;
    end else begin
      case (state)
        M_IDLE: sdaDrive <= next_state == M_START;
        M_LOW: begin
          if (cnt == holdCnt - 12'h001) begin
            sdaDrive <= bitIdx <= LAST_DATA_BIT && !txShift[7];
          end
        end
        M_PAUSE: begin
          if (next_state == M_STOPLOW) begin
            sdaDrive <= 1'b0;
          end
        end
        M_STOPLOW: begin
          if (cnt == holdCnt - 12'h001) begin
            sdaDrive <= 1'b1;
          end
        end
        M_STOPHIGH: begin
          if (next_state == M_IDLE) begin
            sdaDrive <= 1'b0;
          end
        end
        default: sdaDrive <= sdaDrive;
      endcase
    end
  end

  // Clock line drive
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclDrive <= 1'b0;
    end else begin
      sclDrive <= next_state == M_LOW || next_state == M_PAUSE
               || next_state == M_STOPLOW;
    end
  end

  assign sclOe = sclDrive;
  assign sdaOe = sdaDrive;
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign masterActive = state != M_IDLE;

  // Slave address watcher
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slvActive <= 1'b0;
      slvCnt <= 4'h0;
      slvShift <= 7'h00;
    end else if (startSeen) begin
      slvActive <= 1'b1;
      slvCnt <= 4'h0;
    end else if (stopSeen) begin
      slvActive <= 1'b0;
    end else if (slvActive && sclRise) begin
      slvShift <= {slvShift[5:0], sdaSync};
      slvCnt <= slvCnt + 4'h1;
      if (slvCnt == LAST_DATA_BIT) begin
        slvActive <= 1'b0;
      end
    end
  end

  // Status flags, a hardware set wins over a software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= '0;
    end else begin
      if (lost) begin
        status.arbLost <= 1'b1;
      end else if (wrStatus && pwdata[STAT_ARB_BIT]) begin
        status.arbLost <= 1'b0;
      end
      if (slvActive && sclRise && slvCnt == LAST_DATA_BIT && state == M_IDLE
          && slvShift == ownAddr[7:1]) begin
        status.addrMatch <= 1'b1;
        status.slaveRw <= sdaSync;
      end else if (wrStatus && pwdata[STAT_MATCH_BIT]) begin
        status.addrMatch <= 1'b0;
      end
      if (startSeen) begin
        status.busBusy <= 1'b1;
      end else if (stopSeen) begin
        status.busBusy <= 1'b0;
      end
      if (state == M_HIGH && next_state == M_PAUSE) begin
        status.byteDone <= 1'b1;
      end else if (state == M_PAUSE && next_state != M_PAUSE) begin
        status.byteDone <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_arb_release: assert property (lost |=> !sdaOe && !sclOe && state == M_IDLE)
    else $error("data line still driven after arbitration loss");
  a_master_clear: assert property (lost |=> !masterSelect && !sdaDrive)
    else $error("master select not cleared on loss");
  a_arb_flag: assert property (lost |=> status.arbLost)
    else $error("arbitration lost flag not set");
  a_arb_cause: assert property ($rose(status.arbLost) |->
    $past(state == M_HIGH && !sdaSync && !sdaDrive))
    else $error("arbitration flag set without a lost bit");
  a_low_count: assert property (state == M_LOW && cnt == halfDiv - 12'h001
    |=> state == M_HIGHWAIT && !sclOe)
    else $error("clock not released after low count");
  a_high_wait: assert property (state == M_HIGHWAIT && !sclSync
    |=> state == M_HIGHWAIT && cnt == 12'h000)
    else $error("high counted while line held low");
  a_high_count: assert property (state == M_HIGH && sclSync && !lost
    && cnt == halfDiv - HIGH_LAG |=> sclOe)
    else $error("clock not pulled low after high count");
  a_sync_low: assert property (state == M_HIGH && !sclSync && !lost
    |=> (state == M_LOW || state == M_PAUSE) && cnt == 12'h000 && sclOe)
    else $error("low period not restarted on shared clock fall");
  a_sda_hold: assert property (state == M_LOW && cnt == holdCnt - 12'h001
    && bitIdx <= LAST_DATA_BIT |=> sdaOe == !txShift[7])
    else $error("data line not changed at hold count");
  a_own_write: assert property (wrOwn |=> ownAddr == {$past(pwdata[7:1]), 1'b0})
    else $error("own address write wrong");
  a_rate_write: assert property (wrRate |=> rateCode == $past(pwdata[5:0]))
    else $error("rate code write wrong");
  a_div_range: assert property (halfDiv >= HALF_MIN && halfDiv <= HALF_MAX
    && holdCnt >= HOLD_MIN && holdCnt <= HOLD_MAX)
    else $error("divider or hold count out of range");

  c_arb_lost: cover property (lost);
  c_addr_match: cover property ($rose(status.addrMatch));
  c_byte_done: cover property (state == M_HIGH ##1 state == M_PAUSE);
  c_stop_done: cover property (state == M_STOPHIGH ##1 state == M_IDLE);

endmodule : iabc_core

`default_nettype wire

/* dv/iabc_bus_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module iabc_bus_partner (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclLine,
  input wire logic [11:0] stretch,
  input wire logic [3:0] arbFall,
  output logic sclPull,
  output logic sdaPull
);
  logic sclPrev;
  logic [11:0] holdCnt;
  logic [3:0] fallCnt;
  // Slave stretch after each fall
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev <= 1'b1;
      holdCnt <= 12'h000;
    end else begin
      sclPrev <= sclLine;
      if (sclPrev && !sclLine && stretch != 12'h000) begin
        holdCnt <= stretch;
      end else if (holdCnt != 12'h000) begin
        holdCnt <= holdCnt - 12'h001;
      end
    end
  end
  // Rival master counting clock falls
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fallCnt <= 4'h0;
    end else if (arbFall == 4'h0) begin
      fallCnt <= 4'h0;
    end else if (sclPrev && !sclLine && fallCnt != 4'hF) begin
      fallCnt <= fallCnt + 4'h1;
    end
  end
  assign sclPull = (holdCnt != 12'h000);
  assign sdaPull = (arbFall != 4'h0) && (fallCnt >= arbFall);
endmodule : iabc_bus_partner
`default_nettype wire

/* dv/iabc_core_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module iabc_core_tb_top;
  import iabc_pkg::*;
  logic clk, rst_b, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e;
  logic sclOut, sclOe, sdaOut, sdaOe, masterActive;
  logic sclPull, sdaPull, sclLine, sdaLine;
  logic [11:0] stretch;
  logic [3:0] arbFall;
  int n_mismatch, n_tests, cyc, c, lastLow, hold, pullBad, lc, lineLow, pc, per;
  logic ps, pd, pl;
  int divs [3] = '{20, 68, 3840};
  int holds [3] = '{7, 13, 513};
  logic [5:0] codes [3] = '{6'h00, 6'h0F, 6'h3F};
  assign sclLine = !(sclOe | sclPull);
  assign sdaLine = !(sdaOe | sdaPull);
  iabc_core dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclIn(sclLine), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .masterActive(masterActive));
  iabc_bus_partner peer (.clk(clk), .rst_b(rst_b), .sclLine(sclLine),
    .stretch(stretch), .arbFall(arbFall), .sclPull(sclPull), .sdaPull(sdaPull));
  always #5 clk = ~clk;
  // Line timing monitor
  always @(posedge clk) begin
    pc++;
    if (sclOe && !ps) begin
      c = 0;
      per = pc;
      pc = 0;
    end else if (sclOe) begin
      c++;
    end
    if (!sclOe && ps) lastLow = c + 1;
    if (sdaOe !== pd && sclOe && ps) hold = c;
    if (sclOe && !ps && !pl) pullBad++;
    if (!sclLine) lc++;
    else begin
      if (!pl) lineLow = lc;
      lc = 0;
    end
    ps = sclOe;
    pd = sdaOe;
    pl = sclLine;
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic send(input logic [7:0] b);
    apb(1'b1, TXDATA_OFS, {24'h0000_00, b});
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    do begin
      apb(1'b0, STATUS_OFS, 32'h0000_0000);
    end while (q[4] !== 1'b1);
  endtask : send
  task automatic stop_idle();
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    while (masterActive !== 1'b0) begin
      @(posedge clk);
    end
    repeat (20) @(posedge clk);
  endtask : stop_idle
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    stretch = 12'h000;
    arbFall = 4'h0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, OWN_ADDR_OFS, 32'h0000_0000);
    chk("own addr reset", q, 32'h0000_0000);
    apb(1'b0, RATE_OFS, 32'h0000_0000);
    chk("rate reset", q, 32'h0000_0000);
    apb(1'b1, OWN_ADDR_OFS, 32'hFFFF_FFFF);
    apb(1'b0, OWN_ADDR_OFS, 32'h0000_0000);
    chk("own addr bits", q, 32'h0000_00FE);
    apb(1'b1, RATE_OFS, 32'hFFFF_FFFF);
    apb(1'b0, RATE_OFS, 32'h0000_0000);
    chk("rate bits", q, 32'h0000_003F);
    apb(1'b0, 12'h3FC, 32'h0000_0000);
    chk("unmapped err", {31'h0, e}, 32'h0000_0001);
    chk("master idle", {31'h0, masterActive}, 32'h0000_0000);
    chk("pin levels", {30'h0, sclOut, sdaOut}, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, RATE_OFS, {26'h0, codes[i]});
      send(8'h55);
      chk("low period", lastLow, divs[i] / 2);
      chk("data hold", hold, holds[i]);
      chk("period", per, divs[i]);
      stop_idle();
    end
    apb(1'b1, RATE_OFS, 32'h0000_0000);
    stretch <= 12'd30;
    apb(1'b1, OWN_ADDR_OFS, 32'h0000_0054);
    pullBad = 0;
    send(8'h55);
    chk("no self match", {31'h0, q[1]}, 32'h0000_0000);
    chk("own low", lastLow, 10);
    chk("stretched low", lineLow, 31);
    chk("early pull", pullBad, 0);
    stop_idle();
    stretch <= 12'h000;
    arbFall <= 4'h2;
    apb(1'b1, TXDATA_OFS, 32'h0000_00FF);
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    while (masterActive !== 1'b1) begin
      @(posedge clk);
    end
    while (masterActive !== 1'b0) begin
      @(posedge clk);
    end
    chk("data released", {31'h0, sdaOe}, 32'h0000_0000);
    chk("clock released", {31'h0, sclOe}, 32'h0000_0000);
    repeat (50) @(posedge clk);
    chk("no stop", {31'h0, sdaOe}, 32'h0000_0000);
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    chk("master cleared", {31'h0, q[0]}, 32'h0000_0000);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("arb flag", {31'h0, q[0]}, 32'h0000_0001);
    apb(1'b1, STATUS_OFS, 32'h0000_0001);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("arb clear", {31'h0, q[0]}, 32'h0000_0000);
    arbFall <= 4'h0;
    repeat (20) @(posedge clk);
    tally_and_finish();
  end
endmodule : iabc_core_tb_top
`default_nettype wire
